// ==== verilog/adcsi_regs.vh ====
// Constants of the serial conversion interface: bus map, fields, reset values, timing
`ifndef ADCSI_REGS_VH
`define ADCSI_REGS_VH

// ==========================================================
// Timing
`define ADCSI_CLK_PERIOD_NS   40
`define ADCSI_CONV_TIME_NS    4000
`define ADCSI_CONV_CYC        (`ADCSI_CONV_TIME_NS / `ADCSI_CLK_PERIOD_NS)
`define ADCSI_SCLK_PERIOD_NS  320
`define ADCSI_SCLK_CYC        (`ADCSI_SCLK_PERIOD_NS / `ADCSI_CLK_PERIOD_NS)
`define ADCSI_WORD_W          16

// ==========================================================
// Register map (byte addresses)
`define ADCSI_ADDR_W          4
`define ADCSI_OFS_CTRL        4'h0
`define ADCSI_OFS_CONV_TIME   4'h4
`define ADCSI_OFS_STATUS      4'h8
`define ADCSI_OFS_RESULT      4'hc

// ==========================================================
// Fields and reset values
`define ADCSI_CTRL_SYNC_EN    0
`define ADCSI_CTRL_RST        1'b0
`define ADCSI_ST_BUSY         0
`define ADCSI_ST_PWRDN        1
`define ADCSI_ST_INT_SEND     2
`define ADCSI_ST_EXT_READ     3
`define ADCSI_ST_EXT_MODE     4
`define ADCSI_CNT_W           16
`define ADCSI_PH_W            8
`define ADCSI_SH_W            5
`define ADCSI_SH_DONE         5'h10
`define ADCSI_RESP_OKAY       2'h0
`define ADCSI_RESP_SLVERR     2'h2

`endif

// ==== verilog/adcsi_sync.v ====
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module adcsi_sync #(
  parameter integer   W       = 1,
  parameter [W-1:0]   RST_VAL = {W{1'b0}}
)(
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/adcsi_top.v ====
// Conversion control and serial result output with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
`include "adcsi_regs.vh"
module adcsi_top #(
  parameter integer CONV_CYC = `ADCSI_CONV_CYC,
  parameter integer SCLK_CYC = `ADCSI_SCLK_CYC,
  parameter integer WORD_W   = `ADCSI_WORD_W
)(
  input  wire                      aclk,
  input  wire                      aresetn,
  input  wire [`ADCSI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output reg                       s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output reg                       s_axi_wready,
  output reg  [1:0]                s_axi_bresp,
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [`ADCSI_ADDR_W-1:0]  s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output reg                       s_axi_arready,
  output reg  [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready,
  input  wire [WORD_W-1:0]         adc_code,
  input  wire                      read_convert,
  input  wire                      chip_select_n,
  input  wire                      chain_tag,
  input  wire                      power_down_input,
  input  wire                      format_select,
  input  wire                      clock_source_select,
  input  wire                      serial_shift_clock_i,
  output reg                       serial_shift_clock_o,
  output reg                       serial_shift_clock_oe_n,
  output reg                       serial_data,
  output reg                       frame_sync,
  output reg                       busy_n,
  output reg                       low_power
);

  // ==========================================================
  // Constants
  localparam integer PH_RISE_I = SCLK_CYC / 4;
  localparam integer PH_FALL_I = (3 * SCLK_CYC) / 4;
  localparam [`ADCSI_PH_W-1:0] PH_LAST = SCLK_CYC[`ADCSI_PH_W-1:0] - 1'b1;
  localparam [`ADCSI_PH_W-1:0] PH_RISE = PH_RISE_I[`ADCSI_PH_W-1:0];
  localparam [`ADCSI_PH_W-1:0] PH_FALL = PH_FALL_I[`ADCSI_PH_W-1:0];
  localparam [`ADCSI_CNT_W-1:0] CONV_DEF = CONV_CYC[`ADCSI_CNT_W-1:0];

  // ==========================================================
  // Pin synchronisers
  wire [6:0] pins_q;
  wire       rc_q;
  wire       cs_n_q;
  wire       tag_q;
  wire       pd_q;
  wire       fmt_q;
  wire       ext_q;
  wire       sclk_q;

  adcsi_sync #(
    .W       (7),
    .RST_VAL (7'h03)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({serial_shift_clock_i, clock_source_select, format_select,
                power_down_input, chain_tag, chip_select_n, read_convert}),
    .q       (pins_q)
  );

  assign rc_q   = pins_q[0];
  assign cs_n_q = pins_q[1];
  assign tag_q  = pins_q[2];
  assign pd_q   = pins_q[3];
  assign fmt_q  = pins_q[4];
  assign ext_q  = pins_q[5];
  assign sclk_q = pins_q[6];

  // ==========================================================
  // State
  reg                     rc_d_r;
  reg                     cs_n_d_r;
  reg                     sclk_d_r;
  reg                     sync_en_r;
  reg [`ADCSI_CNT_W-1:0]  conv_time_r;
  reg [`ADCSI_CNT_W-1:0]  conv_cnt_r;
  reg [WORD_W-1:0]        result_r;
  reg [WORD_W-1:0]        shift_r;
  reg [`ADCSI_SH_W-1:0]   sh_cnt_r;
  reg [`ADCSI_PH_W-1:0]   ph_r;
  reg                     tag_hold_r;
  reg                     int_act_r;
  reg                     ext_act_r;
  reg                     sync_pend_r;
  reg                     sdata_nxt;
  reg                     sclk_nxt;

  wire rc_fall   = rc_d_r & ~rc_q;
  wire rc_rise   = ~rc_d_r & rc_q;
  wire cs_fall   = cs_n_d_r & ~cs_n_q;
  wire sclk_rise = ~sclk_d_r & sclk_q;
  wire conv_req  = (rc_fall & ~cs_n_q) | (cs_fall & ~rc_q);
  wire conv_go   = conv_req & ~pd_q & busy_n;
  wire conv_done = ~busy_n & (conv_cnt_r == {`ADCSI_CNT_W{1'b0}});
  wire read_go   = ((rc_rise & ~cs_n_q) | (cs_fall & rc_q)) & ext_q & ~ext_act_r;
  wire int_go    = conv_go & ~ext_q;

  // ==========================================================
  // Conversion control
  always @(posedge aclk) begin
    if (!aresetn) begin
      rc_d_r     <= 1'b1;
      cs_n_d_r   <= 1'b1;
      sclk_d_r   <= 1'b0;
      busy_n     <= 1'b1;
      conv_cnt_r <= {`ADCSI_CNT_W{1'b0}};
      result_r   <= {WORD_W{1'b0}};
      tag_hold_r <= 1'b0;
      low_power  <= 1'b0;
    end else begin
      rc_d_r    <= rc_q;
      cs_n_d_r  <= cs_n_q;
      sclk_d_r  <= sclk_q;
      low_power <= pd_q;
      if (conv_go) begin
        busy_n     <= 1'b0;
        conv_cnt_r <= conv_time_r;
        tag_hold_r <= tag_q;
      end else if (conv_done) begin
        busy_n   <= 1'b1;
        // Core delivers straight binary; low format flips the sign bit
        result_r <= fmt_q ? adc_code : {~adc_code[WORD_W-1], adc_code[WORD_W-2:0]};
      end else if (!busy_n) begin
        conv_cnt_r <= conv_cnt_r - 1'b1;
      end
    end
  end

  // ==========================================================
  // Serial output sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      shift_r     <= {WORD_W{1'b0}};
      sh_cnt_r    <= `ADCSI_SH_DONE;
      ph_r        <= {`ADCSI_PH_W{1'b0}};
      int_act_r   <= 1'b0;
      ext_act_r   <= 1'b0;
      sync_pend_r <= 1'b0;
      frame_sync  <= 1'b0;
    end else if (int_go) begin
      // Previous result goes out while the new conversion runs
      shift_r   <= result_r;
      sh_cnt_r  <= {`ADCSI_SH_W{1'b0}};
      ph_r      <= {`ADCSI_PH_W{1'b0}};
      int_act_r <= 1'b1;
      ext_act_r <= 1'b0;
    end else if (read_go) begin
      // Shift register holds the last latched result, old or new
      shift_r     <= result_r;
      sh_cnt_r    <= {`ADCSI_SH_W{1'b0}};
      ext_act_r   <= 1'b1;
      sync_pend_r <= sync_en_r;
      frame_sync  <= 1'b0;
    end else if (int_act_r) begin
      if (ph_r == PH_LAST) begin
        ph_r     <= {`ADCSI_PH_W{1'b0}};
        shift_r  <= {shift_r[WORD_W-2:0], 1'b0};
        sh_cnt_r <= sh_cnt_r + 1'b1;
        if (sh_cnt_r == `ADCSI_SH_DONE - 1'b1) begin
          int_act_r <= 1'b0;
        end
      end else begin
        ph_r <= ph_r + 1'b1;
      end
    end else if (ext_act_r && !ext_q) begin
      ext_act_r   <= 1'b0;
      sync_pend_r <= 1'b0;
      frame_sync  <= 1'b0;
    end else if (ext_act_r && sclk_rise) begin
      if (sync_pend_r) begin
        // Sync spends one clock period before the first shift
        sync_pend_r <= 1'b0;
        frame_sync  <= 1'b1;
      end else begin
        frame_sync <= 1'b0;
        shift_r    <= {shift_r[WORD_W-2:0], 1'b0};
        sh_cnt_r   <= sh_cnt_r + 1'b1;
        if (sh_cnt_r == `ADCSI_SH_DONE - 1'b1) begin
          ext_act_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Pin drivers
  always @* begin
    sdata_nxt = tag_hold_r;
    sclk_nxt  = 1'b0;
    if (int_act_r || ext_act_r) begin
      sdata_nxt = shift_r[WORD_W-1];
    end
    // Bit changes at period start, clock edges sit at a quarter and three quarters
    if (int_act_r && ph_r >= PH_RISE && ph_r < PH_FALL) begin
      sclk_nxt = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      serial_data             <= 1'b0;
      serial_shift_clock_o    <= 1'b0;
      serial_shift_clock_oe_n <= 1'b1;
    end else begin
      serial_data             <= sdata_nxt;
      serial_shift_clock_o    <= sclk_nxt;
      serial_shift_clock_oe_n <= ext_q;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  reg                      aw_hold_r;
  reg                      w_hold_r;
  reg [`ADCSI_ADDR_W-1:0]  awaddr_r;
  reg [31:0]               wdata_r;
  reg [3:0]                wstrb_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ADCSI_RESP_OKAY;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= {`ADCSI_ADDR_W{1'b0}};
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      sync_en_r     <= `ADCSI_CTRL_RST;
      conv_time_r   <= CONV_DEF;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_hold_r     <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_hold_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end
      if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `ADCSI_RESP_OKAY;
        case (awaddr_r)
          `ADCSI_OFS_CTRL: begin
            if (wstrb_r[0]) begin
              sync_en_r <= wdata_r[`ADCSI_CTRL_SYNC_EN];
            end
          end
          `ADCSI_OFS_CONV_TIME: begin
            if (wstrb_r[0]) begin
              conv_time_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
              conv_time_r[15:8] <= wdata_r[15:8];
            end
          end
          `ADCSI_OFS_STATUS,
          `ADCSI_OFS_RESULT: begin
            s_axi_bresp <= `ADCSI_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `ADCSI_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ADCSI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ADCSI_RESP_OKAY;
      case (s_axi_araddr)
        `ADCSI_OFS_CTRL: begin
          s_axi_rdata[`ADCSI_CTRL_SYNC_EN] <= sync_en_r;
        end
        `ADCSI_OFS_CONV_TIME: begin
          s_axi_rdata[15:0] <= conv_time_r;
        end
        `ADCSI_OFS_STATUS: begin
          s_axi_rdata[`ADCSI_ST_BUSY]     <= ~busy_n;
          s_axi_rdata[`ADCSI_ST_PWRDN]    <= low_power;
          s_axi_rdata[`ADCSI_ST_INT_SEND] <= int_act_r;
          s_axi_rdata[`ADCSI_ST_EXT_READ] <= ext_act_r;
          s_axi_rdata[`ADCSI_ST_EXT_MODE] <= ext_q;
        end
        `ADCSI_OFS_RESULT: begin
          s_axi_rdata[WORD_W-1:0] <= result_r;
        end
        default: begin
          s_axi_rresp <= `ADCSI_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ==== tb/adcsi_props.sv ====
// Pin-level checks of the serial conversion interface
`timescale 1ns/1ps
`default_nettype none
module adcsi_props #(
  parameter integer CONV_CYC = 8
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic read_convert,
  input wire logic chip_select_n,
  input wire logic power_down_input,
  input wire logic clock_source_select,
  input wire logic serial_shift_clock_o,
  input wire logic serial_shift_clock_oe_n,
  input wire logic serial_data,
  input wire logic frame_sync,
  input wire logic busy_n,
  input wire logic low_power
);
  logic [7:0] low_cnt_r;
  logic [4:0] rise_cnt_r;
  logic       clk_d_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Busy length and internal clock pulse counters
  always @(posedge aclk) begin
    clk_d_r    <= serial_shift_clock_o;
    low_cnt_r  <= (!aresetn || busy_n) ? 8'h00 : low_cnt_r + 8'h01;
    rise_cnt_r <= (!aresetn || $fell(busy_n)) ? 5'h00 : rise_cnt_r + {4'h0, serial_shift_clock_o & ~clk_d_r};
  end
  sequence rc_start_s;
    $fell(read_convert) && !chip_select_n && busy_n && !power_down_input && !low_power;
  endsequence
  // ==========
  // Assertions
  conv_start_a: assert property (rc_start_s |-> ##[3:5] !busy_n)
    else $error("convert edge did not start busy");
  busy_len_a: assert property ($rose(busy_n) |-> low_cnt_r == CONV_CYC + 1)
    else $error("busy low length wrong");
  pd_block_a: assert property ($fell(busy_n) |-> !low_power)
    else $error("conversion started in power-down");
  clk_dir_a: assert property ($changed(clock_source_select) |-> ##[2:4] serial_shift_clock_oe_n == clock_source_select)
    else $error("clock pin direction wrong");
  int_pulses_a: assert property ($fell(busy_n) && !serial_shift_clock_oe_n |-> ##135 rise_cnt_r == 5'h10 && !serial_shift_clock_o)
    else $error("internal clock pulse count wrong");
  data_hold_a: assert property (!serial_shift_clock_oe_n && (serial_shift_clock_o || $fell(serial_shift_clock_o)) |-> $stable(serial_data))
    else $error("data moved near clock edge");
  sync_mode_a: assert property (frame_sync |-> serial_shift_clock_oe_n)
    else $error("sync in internal mode");
  sync_width_a: assert property ($rose(frame_sync) |-> frame_sync[*7] ##[1:3] !frame_sync)
    else $error("sync width wrong");
endmodule
`default_nettype wire

// ==== tb/adcsi_host.sv ====
// Host-side model: conversion and read pins, gated external clock
`timescale 1ns/1ps
`default_nettype none
module adcsi_host (
  input  wire logic aclk,
  input  wire logic serial_data,
  output var  logic read_convert,
  output var  logic chip_select_n,
  output var  logic ext_clk
);
  initial begin
    read_convert = 1'b1;
    chip_select_n = 1'b1;
    ext_clk = 1'b0;
  end
  // ==========
  // Pin steps held long enough to cross the synchronisers
  task automatic pins(input logic rc, input logic cs);
    @(posedge aclk);
    read_convert <= rc;
    chip_select_n <= cs;
    repeat (6) @(posedge aclk);
  endtask
  // Clock idles low outside frames; 320 ns period; bits taken at each rise after the first skip rises
  task automatic ext_read(input int n, input int skip, output logic [15:0] v, output logic tg);
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge aclk);
      ext_clk <= 1'b1;
      if (i >= skip) v = {v[14:0], serial_data};
      repeat (4) @(posedge aclk);
      ext_clk <= 1'b0;
    end
    repeat (8) @(posedge aclk);
    tg = serial_data;
  endtask
endmodule
`default_nettype wire

// ==== tb/adcsi_top_tb.sv ====
// Bench: register access, internal and external read-out
`timescale 1ns/1ps
`default_nettype none
module adcsi_top_tb;
  localparam integer CC = 8;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [15:0] adc_code = 16'h0, w;
  logic        chain_tag = 1'b1, power_down_input = 1'b0, format_select = 1'b0, clock_source_select = 1'b0;
  logic        read_convert, chip_select_n, serial_shift_clock_i, tg;
  logic        serial_shift_clock_o, serial_shift_clock_oe_n, serial_data, frame_sync, busy_n, low_power;
  int          num_errors = 0, checked = 0;
  always #20 aclk = ~aclk;
  adcsi_top #(.CONV_CYC(CC)) u_dut (.*);
  adcsi_host u_host (.aclk(aclk), .serial_data(serial_data), .read_convert(read_convert),
                     .chip_select_n(chip_select_n), .ext_clk(serial_shift_clock_i));
  // ==========
  // Compare, bus and capture tasks
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    cmp_word("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    cmp_word("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    if (er == 2'h0) cmp_word("rdata", e, s_axi_rdata);
  endtask
  task automatic int_read(output logic [15:0] v);
    v = 16'h0;
    for (int i = 0; i < 16; i++) begin
      @(posedge serial_shift_clock_o);
      v = {v[14:0], serial_data};
    end
  endtask
  task automatic report_and_stop;
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop;
  end
  // ==========
  // Test sequence
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    axr(4'h4, 32'(CC), 2'h0);
    axw(4'hc, 32'hffff);
    axr(4'h2, 32'h0, 2'h2);
    adc_code <= 16'h1234;
    u_host.pins(1'b1, 1'b0);
    u_host.pins(1'b0, 1'b0);
    repeat (140) @(posedge aclk);
    axr(4'hc, 32'h9234, 2'h0);
    cmp_bit("idle_data", 1'b1, serial_data);
    adc_code <= 16'hbeef;
    chain_tag <= 1'b0;
    format_select <= 1'b1;
    u_host.pins(1'b1, 1'b0);
    fork
      u_host.pins(1'b0, 1'b0);
      int_read(w);
    join
    cmp_word("int_word", 32'h9234, {16'h0, w});
    chain_tag <= 1'b1;
    repeat (20) @(posedge aclk);
    cmp_bit("tag_data", 1'b0, serial_data);
    cmp_bit("clk_idle", 1'b0, serial_shift_clock_o);
    axr(4'hc, 32'hbeef, 2'h0);
    power_down_input <= 1'b1;
    u_host.pins(1'b1, 1'b0);
    cmp_bit("low_power", 1'b1, low_power);
    axr(4'h8, 32'h2, 2'h0);
    u_host.pins(1'b0, 1'b0);
    cmp_bit("busy_n", 1'b1, busy_n);
    axr(4'hc, 32'hbeef, 2'h0);
    power_down_input <= 1'b0;
    clock_source_select <= 1'b1;
    adc_code <= 16'h5a3c;
    u_host.pins(1'b0, 1'b1);
    u_host.pins(1'b0, 1'b0);
    u_host.pins(1'b0, 1'b1);
    u_host.pins(1'b1, 1'b1);
    chain_tag <= 1'b0;
    u_host.pins(1'b1, 1'b0);
    u_host.ext_read(16, 0, w, tg);
    cmp_word("ext_word", 32'h5a3c, {16'h0, w});
    cmp_bit("ext_tag", 1'b1, tg);
    u_host.pins(1'b1, 1'b1);
    axw(4'h0, 32'h1);
    axr(4'h0, 32'h1, 2'h0);
    adc_code <= 16'h0f0f;
    u_host.pins(1'b0, 1'b1);
    u_host.pins(1'b0, 1'b0);
    chain_tag <= 1'b1;
    u_host.pins(1'b1, 1'b0);
    u_host.ext_read(17, 1, w, tg);
    cmp_word("sync_word", 32'h5a3c, {16'h0, w});
    cmp_bit("sync_tag", 1'b0, tg);
    axr(4'hc, 32'h0f0f, 2'h0);
    report_and_stop;
  end
endmodule
bind adcsi_top adcsi_props #(.CONV_CYC(CONV_CYC)) u_props (
  .aclk                    (aclk),
  .aresetn                 (aresetn),
  .read_convert            (read_convert),
  .chip_select_n           (chip_select_n),
  .power_down_input        (power_down_input),
  .clock_source_select     (clock_source_select),
  .serial_shift_clock_o    (serial_shift_clock_o),
  .serial_shift_clock_oe_n (serial_shift_clock_oe_n),
  .serial_data             (serial_data),
  .frame_sync              (frame_sync),
  .busy_n                  (busy_n),
  .low_power               (low_power)
);
`default_nettype wire
